// ### hw/loop_shift_amount_control.sv
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`include "agc_loop_consts.svh"
// Notes on behaviour
// - Analog gain word codes 6 dB steps, 000 is -12dB up to 111 +30dB.
// - Digital exponent is bitwise inverse of analog gain word.
// - Mixer word shifted into 22 bits, sign extended, exponent 111 puts bit0 at bit7.
// - Shifted table error feeds the loop integrator.
// - Each channel integrator can load from its own initial value.
// - Top eight integrator bits readable per channel.
// - Top three integrator bits drive gain pins with strobe.
// - Integrator saturates at 0 and 2^11-1.
// - Hold low runs loop free; hold high fixes gain at initial value.
// - Fixed gain drives pins with inverted top three initial value bits.
// - Exponent routed to downconverter unless inhibit bit set.
// - Exponent delayed to match amplifier and converter latency.
// - Strobe toggles only on word change; both asserted in reset and sync.
// - Loop shift amount 0 to 3 selects shift of table output.
// - 32 by 8 software table maps power level to error.
// - 9-bit detector output becomes 3-bit exponent, 2-bit mantissa address.
module loop_shift_amount_control #(
  parameter int MIX_W     = 15,
  parameter int SHIFT_W   = 22,
  parameter int MAX_DELAY = 16
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                sync_in,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Power detector samples, one per channel
  input  wire logic [8:0]          power_a,
  input  wire logic [8:0]          power_b,
  input  wire logic                power_valid,
  // Mixer samples
  input  wire logic [MIX_W-1:0]    mixer_a,
  input  wire logic [MIX_W-1:0]    mixer_b,
  // Amplifier pins
  output logic      [2:0]          analog_gain_word_a,
  output logic      [2:0]          analog_gain_word_b,
  output logic                     gain_strobe_chan_a,
  output logic                     gain_strobe_chan_b,
  // Downconverter exponent and aligned samples
  output logic      [2:0]          digital_gain_exponent_a,
  output logic      [2:0]          digital_gain_exponent_b,
  output logic      [SHIFT_W-1:0]  aligned_a,
  output logic      [SHIFT_W-1:0]  aligned_b
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  agc_loop_pkg::bus_phase_t phase_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  init_reg [2];
  logic [31:0] ctrl_reg;
  agc_loop_pkg::table_entry_t table_mem [32];

  wire take        = hsel && hready && htrans[1];
  wire wr_now      = (phase_reg == agc_loop_pkg::BUS_WRITE);
  wire wr_init_a   = wr_now && (addr_reg == `OFF_INIT_A);
  wire wr_init_b   = wr_now && (addr_reg == `OFF_INIT_B);
  wire wr_ctrl     = wr_now && (addr_reg == `OFF_CTRL);
  wire wr_table    = wr_now && addr_reg[7];
  wire [4:0] tidx  = addr_reg[6:2];

  wire       hold_a    = ctrl_reg[`CTRL_HOLD_A_BIT];
  wire       hold_b    = ctrl_reg[`CTRL_HOLD_B_BIT];
  wire       inhibit   = ctrl_reg[`CTRL_INHIBIT_BIT];
  wire [1:0] shift_amt = ctrl_reg[`CTRL_SHIFT_LSB +: 2];
  wire [3:0] delay_sel = ctrl_reg[`CTRL_DELAY_LSB +: 4];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_reg <= agc_loop_pkg::BUS_IDLE;
      addr_reg  <= 8'h00;
    end else if (hready) begin
      phase_reg <= !take ? agc_loop_pkg::BUS_IDLE :
                   hwrite ? agc_loop_pkg::BUS_WRITE : agc_loop_pkg::BUS_READ;
      addr_reg  <= haddr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      init_reg[0] <= `INIT_RESET;
      init_reg[1] <= `INIT_RESET;
      ctrl_reg    <= `CTRL_RESET | (32'(`DELAY_DEFAULT) << `CTRL_DELAY_LSB);
    end else begin
      if (wr_init_a)
        init_reg[0] <= hwdata[7:0];
      if (wr_init_b)
        init_reg[1] <= hwdata[7:0];
      if (wr_ctrl)
        ctrl_reg <= hwdata & 32'h0000_0f37;
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_table)
      table_mem[tidx] <= hwdata[7:0];
  end

  // ----------------------------------------
  // Per-channel loop
  // ----------------------------------------
  // ----------------------------------------
  // Detector sample decimation
  // ----------------------------------------
  logic [2:0] dec_reg;
  wire        dec_wrap    = (dec_reg == `DECIM_COUNT);
  wire        sample_tick = power_valid && dec_wrap;
  wire        init_load   = sync_in;
  wire        dec_clear   = !rst_n || sync_in;

  // One integrator step per eight detector samples
  always_ff @(posedge mclk) begin
    if (dec_clear)
      dec_reg <= 3'h0;
    else if (power_valid)
      dec_reg <= dec_reg + 3'h1;
  end

  logic [7:0] readback [2];
  logic [2:0] word_dly [2][MAX_DELAY];

  // ----------------------------------------
  // Per-channel loop
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      wire [8:0]       pwr  = (ch == 0) ? power_a : power_b;
      wire [MIX_W-1:0] mix  = (ch == 0) ? mixer_a : mixer_b;
      wire             hold = (ch == 0) ? hold_a : hold_b;

      // --------------------------------------
      // Fixed to float table address
      // --------------------------------------
      logic [2:0] lead;
      logic [1:0] mant;

      // Leading one picks the exponent, next two bits the mantissa
      always_comb begin
        lead = 3'h0;
        mant = pwr[1:0];
        for (int i = 2; i < 9; i++) begin
          if (pwr[i]) begin
            lead = 3'(i - 1);
            mant = pwr[i-1 -: 2];
          end
        end
      end

      wire [4:0] taddr = {lead, mant};

      // --------------------------------------
      // Error lookup and loop shift
      // --------------------------------------
      wire signed [7:0]  err  = table_mem[taddr];
      wire signed [12:0] errs = 13'(err) <<< shift_amt;
      wire signed [13:0] errx = 14'(errs);

      // --------------------------------------
      // Saturating integrator
      // --------------------------------------
      logic [10:0]       integ_reg;
      wire [10:0]        init_full  = {init_reg[ch], 3'h0};
      wire signed [13:0] integ_x    = $signed({3'b000, integ_reg});
      wire signed [13:0] sum        = integ_x + errx;
      wire signed [13:0] top        = $signed(14'(`INTEG_MAX));
      wire               under      = (sum < 14'sh0);
      wire               over       = (sum > top);
      wire [10:0]        sat        = under ? 11'h000 :
                                      over  ? `INTEG_MAX : sum[10:0];
      wire               integ_load = !rst_n || init_load;

      // Hold keeps reloading so release starts from the written value
      always_ff @(posedge mclk) begin
        if (integ_load)
          integ_reg <= init_full;
        else if (hold)
          integ_reg <= init_full;
        else if (sample_tick)
          integ_reg <= sat;
      end

      // --------------------------------------
      // Gain word and strobe
      // --------------------------------------
      logic [2:0] prev_reg;
      logic       strobe_reg;
      wire [2:0]  loop_word  = integ_reg[10:8];
      wire [2:0]  fixed_word = ~init_reg[ch][7:5];
      wire [2:0]  word       = hold ? fixed_word : loop_word;
      wire        word_moved = (word != prev_reg);
      wire        strobe_set = !rst_n || sync_in;

      // Strobe only toggles on a new word to keep the analog path quiet
      always_ff @(posedge mclk) begin
        if (strobe_set) begin
          prev_reg   <= fixed_word;
          strobe_reg <= 1'b1;
        end else begin
          prev_reg   <= word;
          strobe_reg <= word_moved ? ~strobe_reg : strobe_reg;
        end
      end

      // --------------------------------------
      // Exponent delay line
      // --------------------------------------
      always_ff @(posedge mclk) begin
        word_dly[ch][0] <= ~word;
        for (int k = 1; k < MAX_DELAY; k++)
          word_dly[ch][k] <= word_dly[ch][k-1];
      end

      wire [2:0] exp_late = word_dly[ch][delay_sel];
      wire [2:0] exp_d    = inhibit ? 3'h7 : exp_late;

      // --------------------------------------
      // Shift-up alignment
      // --------------------------------------
      wire signed [SHIFT_W-1:0] ext     = SHIFT_W'($signed(mix));
      wire signed [SHIFT_W-1:0] ext_top = SHIFT_W'(ext <<< 7);
      wire [2:0]                drop    = 3'h7 - exp_d;
      logic [SHIFT_W-1:0]       aligned_reg;

      always_ff @(posedge mclk) begin
        aligned_reg <= ext_top >>> drop;
      end

      assign readback[ch] = integ_reg[10:3];

      if (ch == 0) begin : g_a
        assign analog_gain_word_a      = prev_reg;
        assign gain_strobe_chan_a      = strobe_reg;
        assign digital_gain_exponent_a = exp_d;
        assign aligned_a               = aligned_reg;
      end else begin : g_b
        assign analog_gain_word_b      = prev_reg;
        assign gain_strobe_chan_b      = strobe_reg;
        assign digital_gain_exponent_b = exp_d;
        assign aligned_b               = aligned_reg;
      end
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdata_reg;
  wire         rd_take = take && !hwrite;
  wire [4:0]   rd_idx  = haddr[6:2];
  wire         sel_ia  = (haddr == `OFF_INIT_A);
  wire         sel_ib  = (haddr == `OFF_INIT_B);
  wire         sel_ct  = (haddr == `OFF_CTRL);
  wire         sel_ra  = (haddr == `OFF_READBACK_A);
  wire         sel_rb  = (haddr == `OFF_READBACK_B);
  wire         sel_tb  = haddr[7];

  wire [31:0] rd_mux =
    sel_ia ? {24'h0, init_reg[0]} :
    sel_ib ? {24'h0, init_reg[1]} :
    sel_ct ? ctrl_reg :
    sel_ra ? {24'h0, readback[0]} :
    sel_rb ? {24'h0, readback[1]} :
    sel_tb ? {24'h0, table_mem[rd_idx]} : 32'h0;

  // Captured in the address phase; a read right behind a write to
  // the same register returns the value before that write
  always_ff @(posedge mclk) begin
    if (!rst_n)
      rdata_reg <= 32'h0;
    else if (hready)
      rdata_reg <= rd_take ? rd_mux : 32'h0;
  end

  assign hrdata = rdata_reg;

endmodule

// ### hw/agc_loop_consts.svh
`ifndef AGC_LOOP_CONSTS_SVH
`define AGC_LOOP_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_INIT_A     8'h00
`define OFF_INIT_B     8'h04
`define OFF_CTRL       8'h08
`define OFF_READBACK_A 8'h0c
`define OFF_READBACK_B 8'h10
`define OFF_TABLE_BASE 8'h80

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_HOLD_A_BIT  0
`define CTRL_HOLD_B_BIT  1
`define CTRL_INHIBIT_BIT 2
`define CTRL_SHIFT_LSB   4
`define CTRL_DELAY_LSB   8

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define INIT_RESET     8'h00
`define CTRL_RESET     32'h0000_0000
`define INTEG_MAX      11'h7ff
`define DECIM_COUNT    3'h7
`define DELAY_DEFAULT  4'h4

`endif

// ### hw/agc_loop_pkg.sv
package agc_loop_pkg;
  typedef logic [2:0]  gain_word_t;
  typedef logic [10:0] integ_t;
  typedef logic [7:0]  table_entry_t;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_phase_t;
endpackage

// ### tb/agc_loop_monitor.sv
`timescale 1ns/10ps
module agc_loop_monitor (
  // Watched top ports
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       sync_in,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [2:0] analog_gain_word_a,
  input wire logic [2:0] analog_gain_word_b,
  input wire logic       gain_strobe_chan_a,
  input wire logic       gain_strobe_chan_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (hreadyout) else $error("bus stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_sync_strobe_a: assert property (sync_in |=> gain_strobe_chan_a) else $error("a low");
  a_sync_strobe_b: assert property (sync_in |=> gain_strobe_chan_b) else $error("b low");
  a_strobe_cause_a: assert property ($changed(gain_strobe_chan_a) |->
    $changed(analog_gain_word_a) || $past(sync_in)) else $error("stray strobe a");
  a_strobe_cause_b: assert property ($changed(gain_strobe_chan_b) |->
    $changed(analog_gain_word_b) || $past(sync_in)) else $error("stray strobe b");
  a_strobe_sent_a: assert property ($changed(analog_gain_word_a) && !$past(sync_in) |->
    $changed(gain_strobe_chan_a)) else $error("word a unstrobed");
  a_strobe_sent_b: assert property ($changed(analog_gain_word_b) && !$past(sync_in) |->
    $changed(gain_strobe_chan_b)) else $error("word b unstrobed");
endmodule
bind loop_shift_amount_control agc_loop_monitor mon (.mclk, .rst_n, .sync_in, .hreadyout, .hresp,
  .analog_gain_word_a, .analog_gain_word_b, .gain_strobe_chan_a, .gain_strobe_chan_b);

// ### tb/vga_model.sv
`timescale 1ns/10ps
module vga_model (
  // Amplifier pins
  input  wire logic [2:0] gain_word,
  input  wire logic       strobe,
  output logic      [2:0] held_gain
);
  // Gain register loads on each strobe edge
  // Word and strobe leave the same edge; latch once both have settled
  always @(strobe) begin
    #1 held_gain = gain_word;
  end
endmodule

// ### tb/loop_shift_amount_control_test.sv
`timescale 1ns/10ps
module loop_shift_amount_control_test;
  logic        mclk = 1'b0, rst_n, sync_in, hsel, hwrite, pvalid, stb_a, stb_b, rdy, hresp;
  logic [1:0]  htrans;
  logic [2:0]  word_a, word_b, exp_a, exp_b, amp_a, amp_b, g;
  logic [7:0]  haddr, v;
  logic [8:0]  pow_a, pow_b;
  logic [14:0] mix_a, mix_b;
  logic [21:0] al_a, al_b;
  logic [31:0] hwdata, hrdata, rd;
  int          n_errors, checks_done, seed, k;
  loop_shift_amount_control dut (.mclk, .rst_n, .sync_in, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy), .hresp, .power_a(pow_a),
    .power_b(pow_b), .power_valid(pvalid), .mixer_a(mix_a), .mixer_b(mix_b),
    .analog_gain_word_a(word_a), .analog_gain_word_b(word_b), .gain_strobe_chan_a(stb_a),
    .gain_strobe_chan_b(stb_b), .digital_gain_exponent_a(exp_a),
    .digital_gain_exponent_b(exp_b), .aligned_a(al_a), .aligned_b(al_b));
  vga_model ua (.gain_word(word_a), .strobe(stb_a), .held_gain(amp_a));
  vga_model ub (.gain_word(word_b), .strobe(stb_b), .held_gain(amp_b));
  function automatic logic [21:0] align(input logic [14:0] m, input logic [2:0] e);
    return {{7{m[14]}}, m} << e;
  endfunction
  task automatic wrap_up(input int late);
    n_errors += late;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic settle();
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (rdy === 1'b1) break;
    end
    if (k == 40) wrap_up(1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, wr};
    settle();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    settle();
    rd = hrdata;
  endtask
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) {pow_a, pow_b} <= 18'($random(seed));
  initial begin
    {rst_n, sync_in, hsel, hwrite, pvalid, htrans, haddr, hwdata} = '0;
    {pow_a, pow_b, mix_a, mix_b, n_errors, checks_done} = '0;
    seed = 60;
    repeat (10) @(posedge mclk);
    chk(stb_a & stb_b, 1'b1);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 9; i++) begin
      v = {i[2:0], 5'($random(seed))};
      g = (i < 8) ? v[7:5] : 3'h7;
      {mix_a, mix_b} <= 30'($random(seed));
      bus(1'b1, 8'h08, 32'h0);
      bus(1'b1, 8'h00, {24'h0, v});
      bus(1'b1, 8'h04, {24'h0, ~v});
      bus(1'b1, 8'h08, (i < 8) ? 32'h3 | (i % 4) << 4 : 32'h7);
      repeat (30) @(posedge mclk);
      chk(word_a, 3'(~v[7:5]));
      chk(amp_a, 3'(~v[7:5]));
      chk(word_b, v[7:5]);
      chk(exp_a, g);
      chk(al_a, align(mix_a, g));
      $display("test fixed gain %0d done", i);
    end
    sync_in <= 1'b1;
    @(posedge mclk);
    sync_in <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      for (int t = 0; t < 32; t++) bus(1'b1, 8'(128 + 4 * t), s ? 32'h80 : 32'h7f);
      bus(1'b1, 8'h08, 32'h30);
      pvalid <= 1'b1;
      repeat (6000) @(posedge mclk);
      pvalid <= 1'b0;
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, s ? 32'h0 : 32'hff);
      chk(word_b, s ? 3'h0 : 3'h7);
      $display("test free run %0d done", s);
    end
    wrap_up(0);
  end
endmodule
